// ===== design/nfom_ctrl.v
// Behaviour
// R1: bit 7 enables oscillator and regulators
// R2: bit 6 enables receive operation
// R3: bit 5 selects one or both channels
// R4: bit 4 selects manual or automatic channel
// R5: transmit enable, set by field-on, cleared
// R6: bit 2 enters wake-up mode
// R7: field detector mode decoded from bits 1:0
// R8: detector only gives low power mode
// R9: operation control defaults only at power-up
// R10: bit 7 role, bits 6:3 protocol
// R11: bit 2 selects OOK or AM
// R12: auto response field decode
// R13: mode writes only with crystal stable
// R14: initiator protocol codes decoded
// R15: unsupported initiator mode disables tx/rx
// R16: target codes and bit rate detection
// R17: host avoids frame format in detection
// R18: passive target uses pt drive resistance
`timescale 1ns/10ps
`default_nettype none
`include "nfom_regs.vh"
module nfom_ctrl (
  input  wire        i_core_clk,
  input  wire        i_resetn,
  input  wire        i_por_n,
  input  wire        i_psel,
  input  wire        i_penable,
  input  wire        i_pwrite,
  input  wire [11:0] i_paddr,
  input  wire [31:0] i_pwdata,
  input  wire [3:0]  i_pstrb,
  output reg  [31:0] o_prdata,
  output reg         o_pready,
  output reg         o_pslverr,
  input  wire        i_xtal_stable,
  input  wire        i_field_on_cmd,
  input  wire        i_tx_done,
  output reg         o_osc_reg_on,
  output reg         o_rx_enable,
  output reg         o_am_chn_on,
  output reg         o_pm_chn_on,
  output reg         o_chn_auto,
  output reg         o_chn_pick_pm,
  output reg         o_tx_enable,
  output reg         o_wakeup_mode_on,
  output reg         o_fd_on,
  output reg         o_fd_ca_thr,
  output reg         o_fd_peer_thr,
  output reg         o_fd_auto,
  output reg         o_low_power_nfc,
  output reg         o_target,
  output reg  [3:0]  o_protocol,
  output reg         o_mode_supported,
  output reg         o_brd_mode,
  output reg         o_brd_type_f,
  output reg         o_brd_type_a,
  output reg         o_modulation_kind,
  output reg  [1:0]  o_auto_resp,
  output reg         o_passive_drive,
  output reg  [3:0]  o_drive_res,
  output reg         o_frame_fmt
);

  // Two-stage synchronisers for the pins from other domains.
  reg        por_s1_q;
  reg        por_s2_q;
  reg        xtal_s1_q;
  reg        xtal_s2_q;
  reg        fon_s1_q;
  reg        fon_s2_q;
  reg        fon_s3_q;
  reg        txd_s1_q;
  reg        txd_s2_q;
  reg        txd_s3_q;
  reg  [7:0] opctl_q;
  reg  [7:0] opctl_d;
  reg  [7:0] mode_q;
  reg  [7:0] setup_q;
  reg        mode_wr_drop_q;
  reg        mode_wr_drop_d;
  reg  [31:0] rdata_d;
  reg        err_d;
  reg        supp_d;
  reg        tx_allow;

  wire       access;
  wire       wr_en;
  wire       wr_opctl;
  wire       wr_mode;
  wire       wr_setup;
  wire       wr_status;
  wire       field_on_pulse;
  wire       tx_done_pulse;
  wire [3:0] prot;
  wire       role_t;
  wire       active_p2p;
  wire       addr_ok;

  // Synchronisers run on every rising edge; the first stage feeds only the second.
  always @(posedge i_core_clk) begin
    por_s1_q  <= i_por_n;
    por_s2_q  <= por_s1_q;
    xtal_s1_q <= i_xtal_stable;
    xtal_s2_q <= xtal_s1_q;
    fon_s1_q  <= i_field_on_cmd;
    fon_s2_q  <= fon_s1_q;
    fon_s3_q  <= fon_s2_q;
    txd_s1_q  <= i_tx_done;
    txd_s2_q  <= txd_s1_q;
    txd_s3_q  <= txd_s2_q;
  end

  assign field_on_pulse = fon_s2_q & ~fon_s3_q;
  assign tx_done_pulse  = txd_s2_q & ~txd_s3_q;

  // APB decode; pready answers one cycle after the access phase begins, so one wait state.
  assign access    = i_psel & i_penable & ~o_pready;
  assign wr_en     = access & i_pwrite & i_pstrb[0];
  assign addr_ok   = (i_paddr == `NFOM_ADDR_OPCTL) |
                     (i_paddr == `NFOM_ADDR_MODE) |
                     (i_paddr == `NFOM_ADDR_STATUS) |
                     (i_paddr == `NFOM_ADDR_SETUP);
  assign wr_opctl  = wr_en & (i_paddr == `NFOM_ADDR_OPCTL);
  assign wr_mode   = wr_en & (i_paddr == `NFOM_ADDR_MODE);
  assign wr_setup  = wr_en & (i_paddr == `NFOM_ADDR_SETUP);
  assign wr_status = wr_en & (i_paddr == `NFOM_ADDR_STATUS);
  assign prot      = mode_q[`NFOM_MD_PROT_HI:`NFOM_MD_PROT_LO];
  assign role_t    = mode_q[`NFOM_MD_TARGET];
  assign active_p2p = role_t ? (prot == `NFOM_TP_P2P)
                             : (prot == `NFOM_IP_P2P);

  // Next value of operation control: software write, then hardware updates.
  always @* begin
    opctl_d = opctl_q;
    if (wr_opctl) begin
      opctl_d = i_pwdata[7:0];
    end
    // R5: tx hardware update
    if (tx_done_pulse & active_p2p) begin
      opctl_d[`NFOM_OP_TX_EN] = 1'b0;
    end
    // R5: field-on sets tx
    if (field_on_pulse) begin
      opctl_d[`NFOM_OP_TX_EN] = 1'b1;
    end
  end

  // Sticky flag for a mode write refused; a fresh refusal beats the clear.
  always @* begin
    mode_wr_drop_d = mode_wr_drop_q;
    if (wr_status & i_pwdata[0]) begin
      mode_wr_drop_d = 1'b0;
    end
    if (wr_mode & ~xtal_s2_q) begin
      mode_wr_drop_d = 1'b1;
    end
  end

  // R9: power-up default only
  always @(posedge i_core_clk) begin
    if (!por_s2_q) begin
      opctl_q <= `NFOM_OPCTL_RST;
    end else begin
      opctl_q <= opctl_d;
    end
  end

  // Mode and setup live on the ordinary reset; the mode write is gated.
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      mode_q         <= `NFOM_MODE_RST;
      setup_q        <= `NFOM_SETUP_RST;
      mode_wr_drop_q <= 1'b0;
    end else begin
      mode_wr_drop_q <= mode_wr_drop_d;
      // R13: crystal stable gate
      if (wr_mode & xtal_s2_q) begin
        mode_q <= i_pwdata[7:0];
      end
      if (wr_setup) begin
        setup_q <= i_pwdata[7:0];
      end
    end
  end

  // Read mux; unmapped addresses answer with an error and zero data.
  always @* begin
    rdata_d = 32'h0000_0000;
    err_d   = ~addr_ok;
    case (i_paddr)
      `NFOM_ADDR_OPCTL:  rdata_d[7:0] = opctl_q;
      `NFOM_ADDR_MODE:   rdata_d[7:0] = mode_q;
      `NFOM_ADDR_SETUP:  rdata_d[7:0] = setup_q;
      `NFOM_ADDR_STATUS: rdata_d[3:0] = {o_low_power_nfc, supp_d,
                                         xtal_s2_q, mode_wr_drop_q};
      default:           rdata_d = 32'h0000_0000;
    endcase
  end

  // APB answer registers.
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_pready  <= 1'b0;
      o_prdata  <= 32'h0000_0000;
      o_pslverr <= 1'b0;
    end else begin
      o_pready  <= access;
      o_pslverr <= access & err_d;
      if (access & ~i_pwrite) begin
        o_prdata <= rdata_d;
      end
    end
  end

  // Protocol legality per role.
  always @* begin
    supp_d = 1'b0;
    if (role_t) begin
      // R16: target code check
      if (prot[3]) begin
        supp_d = 1'b1;
      end else begin
        case (prot)
          `NFOM_TP_A:   supp_d = 1'b1;
          `NFOM_TP_F:   supp_d = 1'b1;
          `NFOM_TP_P2P: supp_d = 1'b1;
          default:      supp_d = 1'b0;
        endcase
      end
    end else begin
      // R14: initiator code check
      case (prot)
        `NFOM_IP_P2P:  supp_d = 1'b1;
        `NFOM_IP_A:    supp_d = 1'b1;
        `NFOM_IP_B:    supp_d = 1'b1;
        `NFOM_IP_F:    supp_d = 1'b1;
        `NFOM_IP_T1T:  supp_d = 1'b1;
        `NFOM_IP_SUBC: supp_d = 1'b1;
        `NFOM_IP_BPSK: supp_d = 1'b1;
        default:       supp_d = 1'b0;
      endcase
    end
    // R15: unsupported disables tx/rx
    tx_allow = supp_d;
  end

  // Decoded control outputs, all registered.
  always @(posedge i_core_clk) begin
    if (!i_resetn) begin
      o_osc_reg_on      <= 1'b0;
      o_rx_enable       <= 1'b0;
      o_am_chn_on       <= 1'b0;
      o_pm_chn_on       <= 1'b0;
      o_chn_auto        <= 1'b0;
      o_chn_pick_pm     <= 1'b0;
      o_tx_enable       <= 1'b0;
      o_wakeup_mode_on  <= 1'b0;
      o_fd_on           <= 1'b0;
      o_fd_ca_thr       <= 1'b0;
      o_fd_peer_thr     <= 1'b0;
      o_fd_auto         <= 1'b0;
      o_low_power_nfc   <= 1'b0;
      o_target          <= 1'b0;
      o_protocol        <= 4'h0;
      o_mode_supported  <= 1'b0;
      o_brd_mode        <= 1'b0;
      o_brd_type_f      <= 1'b0;
      o_brd_type_a      <= 1'b0;
      o_modulation_kind <= 1'b0;
      o_auto_resp       <= 2'h0;
      o_passive_drive   <= 1'b0;
      o_drive_res       <= 4'h0;
      o_frame_fmt       <= 1'b0;
    end else begin
      // R1: oscillator enable
      o_osc_reg_on     <= opctl_q[`NFOM_OP_EN];
      // R2: receive enable
      o_rx_enable      <= opctl_q[`NFOM_OP_RX_EN] & tx_allow;
      // R3: channel count
      o_am_chn_on      <= ~opctl_q[`NFOM_OP_ONE_CHN] |
                          ~setup_q[`NFOM_SU_PATH];
      o_pm_chn_on      <= ~opctl_q[`NFOM_OP_ONE_CHN] |
                          setup_q[`NFOM_SU_PATH];
      // R4: channel selection method
      o_chn_auto       <= ~opctl_q[`NFOM_OP_ONE_CHN] &
                          ~opctl_q[`NFOM_OP_MAN_CHN];
      o_chn_pick_pm    <= setup_q[`NFOM_SU_PATH];
      // R5: tx enable output
      o_tx_enable      <= opctl_q[`NFOM_OP_TX_EN] & tx_allow;
      // R6: wake-up mode
      o_wakeup_mode_on <= opctl_q[`NFOM_OP_WAKEUP];
      // R7: field detector decode
      o_fd_on          <= opctl_q[1:0] != `NFOM_FD_OFF;
      o_fd_ca_thr      <= (opctl_q[1:0] == `NFOM_FD_CA) |
                          (opctl_q[1:0] == `NFOM_FD_AUTO);
      o_fd_peer_thr    <= (opctl_q[1:0] == `NFOM_FD_PEER) |
                          (opctl_q[1:0] == `NFOM_FD_AUTO);
      o_fd_auto        <= opctl_q[1:0] == `NFOM_FD_AUTO;
      // R8: low power initial mode
      o_low_power_nfc  <= (opctl_q[1:0] != `NFOM_FD_OFF) &
                          (opctl_q[7:2] == 6'h00);
      // R10: role and protocol
      o_target         <= role_t;
      o_protocol       <= prot;
      o_mode_supported <= supp_d;
      // R16: bit rate detection
      o_brd_mode       <= role_t & prot[3];
      o_brd_type_f     <= role_t & prot[3] & prot[2];
      o_brd_type_a     <= role_t & prot[3] & prot[0];
      // R11: modulation kind
      o_modulation_kind <= mode_q[`NFOM_MD_MODKIND];
      // R12: auto response, reserved code treated as off
      o_auto_resp      <= (mode_q[1:0] == `NFOM_AR_ANY) ? `NFOM_AR_ANY :
                          (mode_q[1:0] == `NFOM_AR_PEEROFF) ?
                          `NFOM_AR_PEEROFF : `NFOM_AR_OFF;
      // R18: passive target drive
      o_passive_drive  <= role_t & (prot[3] | (prot == `NFOM_TP_A) |
                                    (prot == `NFOM_TP_F));
      o_drive_res      <= setup_q[`NFOM_SU_PTRES_HI:`NFOM_SU_PTRES_LO];
      // R17: frame format forced off in detection mode
      o_frame_fmt      <= setup_q[`NFOM_SU_FRAME] & ~(role_t & prot[3]);
    end
  end

endmodule
`default_nettype wire

// ===== design/nfom_regs.vh
`ifndef NFOM_REGS_VH
`define NFOM_REGS_VH
// Register byte addresses (printed offsets 02h, 03h are indices).
`define NFOM_IDX_OPCTL     8'h02
`define NFOM_IDX_MODE      8'h03
`define NFOM_ADDR_OPCTL    12'h008
`define NFOM_ADDR_MODE     12'h00c
`define NFOM_ADDR_STATUS   12'h010
`define NFOM_ADDR_SETUP    12'h014
// Reset values.
`define NFOM_OPCTL_RST     8'h00
`define NFOM_MODE_RST      8'h08
`define NFOM_SETUP_RST     8'h00
// Operation control fields.
`define NFOM_OP_EN         7
`define NFOM_OP_RX_EN      6
`define NFOM_OP_ONE_CHN    5
`define NFOM_OP_MAN_CHN    4
`define NFOM_OP_TX_EN      3
`define NFOM_OP_WAKEUP     2
`define NFOM_OP_FD_HI      1
`define NFOM_OP_FD_LO      0
// Mode definition fields.
`define NFOM_MD_TARGET     7
`define NFOM_MD_PROT_HI    6
`define NFOM_MD_PROT_LO    3
`define NFOM_MD_MODKIND    2
`define NFOM_MD_AR_HI      1
`define NFOM_MD_AR_LO      0
// Setup register fields (receive path choice, frame format, pt resistance).
`define NFOM_SU_PATH       0
`define NFOM_SU_FRAME      1
`define NFOM_SU_PTRES_LO   4
`define NFOM_SU_PTRES_HI   7
// Field detector modes.
`define NFOM_FD_OFF        2'h0
`define NFOM_FD_CA         2'h1
`define NFOM_FD_PEER       2'h2
`define NFOM_FD_AUTO       2'h3
// Auto response modes.
`define NFOM_AR_OFF        2'h0
`define NFOM_AR_ANY        2'h1
`define NFOM_AR_PEEROFF    2'h2
// Initiator protocol codes.
`define NFOM_IP_P2P        4'h0
`define NFOM_IP_A          4'h1
`define NFOM_IP_B          4'h2
`define NFOM_IP_F          4'h3
`define NFOM_IP_T1T        4'h4
`define NFOM_IP_SUBC       4'he
`define NFOM_IP_BPSK       4'hf
// Target protocol codes.
`define NFOM_TP_A          4'h1
`define NFOM_TP_F          4'h4
`define NFOM_TP_P2P        4'h7
`endif

// ===== tb/nfom_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
`include "nfom_regs.vh"
module nfom_ctrl_chk (
  input wire logic        i_core_clk,
  input wire logic        i_resetn,
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0]  i_pstrb,
  input wire logic        o_pready,
  input wire logic        o_osc_reg_on,
  input wire logic        o_rx_enable,
  input wire logic        o_tx_enable,
  input wire logic        o_wakeup_mode_on,
  input wire logic        o_fd_on,
  input wire logic        o_fd_ca_thr,
  input wire logic        o_fd_peer_thr,
  input wire logic        o_fd_auto,
  input wire logic        o_low_power_nfc,
  input wire logic        o_target,
  input wire logic [3:0]  o_protocol,
  input wire logic        o_mode_supported,
  input wire logic        o_brd_mode,
  input wire logic [1:0]  o_auto_resp
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);
  // An access phase not yet answered, and a taken control write.
  sequence s_take;
    i_psel && i_penable && !o_pready;
  endsequence
  sequence s_opwr;
    s_take ##0 (i_pwrite && i_pstrb[0] && i_paddr == `NFOM_ADDR_OPCTL);
  endsequence
  // Enables show two edges after the write edge, decodes hold always.
  a_one_wait: assert property (s_take |=> o_pready)
    else $error("pready late");
  a_ready_pulse: assert property (o_pready |=> !o_pready)
    else $error("pready too long");
  a_osc_follow: assert property (
    s_opwr |-> ##2 (o_osc_reg_on == $past(i_pwdata[7], 2)))
    else $error("oscillator enable wrong");
  a_wake_follow: assert property (
    s_opwr |-> ##2 (o_wakeup_mode_on == $past(i_pwdata[2], 2)))
    else $error("wakeup enable wrong");
  a_fd_decode: assert property (o_fd_auto == (o_fd_ca_thr && o_fd_peer_thr)
    && o_fd_on == (o_fd_ca_thr || o_fd_peer_thr)) else $error("fd decode");
  a_low_power: assert property (o_low_power_nfc |-> o_fd_on
    && !o_osc_reg_on && !o_wakeup_mode_on && !o_tx_enable)
    else $error("low power wrong");
  a_unsup_gate: assert property (
    !o_mode_supported |-> !o_tx_enable && !o_rx_enable)
    else $error("unsupported mode not gated");
  a_brd_decode: assert property (
    o_brd_mode == (o_target && o_protocol[3])) else $error("brd decode");
  a_ar_reserved: assert property (o_auto_resp != 2'h3)
    else $error("reserved auto response shown");
endmodule
`default_nettype wire

// ===== tb/nfom_host.sv
`timescale 1ns/10ps
`default_nettype none
module nfom_host (
  input  wire logic        i_core_clk,
  input  wire logic        i_pready,
  input  wire logic        i_pslverr,
  input  wire logic [31:0] i_prdata,
  output var  logic        o_psel,
  output var  logic        o_penable,
  output var  logic        o_pwrite,
  output var  logic [11:0] o_paddr,
  output var  logic [31:0] o_pwdata,
  output var  logic [3:0]  o_pstrb
);
  // Bus idles with select low; all lanes always enabled.
  initial begin
    o_psel = 1'b0;
    o_penable = 1'b0;
    o_pwrite = 1'b0;
    o_paddr = 12'h000;
    o_pwdata = 32'h0;
    o_pstrb = 4'hf;
  end
  // Entered just after an edge; request held until pready is sampled.
  task automatic xfer(input logic w, input logic [11:0] a,
                      input logic [31:0] d, output logic [31:0] q,
                      output logic e);
    o_psel <= 1'b1;
    o_pwrite <= w;
    o_paddr <= a;
    o_pwdata <= d;
    @(posedge i_core_clk);
    o_penable <= 1'b1;
    @(posedge i_core_clk);
    while (i_pready !== 1'b1) @(posedge i_core_clk);
    q = i_prdata;
    e = i_pslverr;
    o_psel <= 1'b0;
    o_penable <= 1'b0;
    @(posedge i_core_clk);
  endtask
endmodule
`default_nettype wire

// ===== tb/testbench.sv
`timescale 1ns/10ps
`default_nettype none
`include "nfom_regs.vh"
module testbench;
  logic        i_core_clk = 1'b0;
  logic        i_resetn = 1'b0;
  logic        i_por_n = 1'b0;
  logic        i_xtal_stable = 1'b0;
  logic        i_field_on_cmd = 1'b0;
  logic        i_tx_done = 1'b0;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [11:0] i_paddr, e;
  logic [7:0]  d;
  logic [3:0]  i_pstrb, o_protocol, o_drive_res;
  logic [1:0]  o_auto_resp;
  logic        i_psel, i_penable, i_pwrite, o_pready, o_pslverr, err;
  logic        o_osc_reg_on, o_rx_enable, o_am_chn_on, o_pm_chn_on;
  logic        o_chn_auto, o_chn_pick_pm, o_tx_enable, o_wakeup_mode_on;
  logic        o_fd_on, o_fd_ca_thr, o_fd_peer_thr, o_fd_auto;
  logic        o_low_power_nfc, o_target, o_mode_supported, o_brd_mode;
  logic        o_brd_type_f, o_brd_type_a, o_modulation_kind;
  logic        o_passive_drive, o_frame_fmt;
  int          error_cnt = 0;
  int          compares = 0;
  int          cyc = 0;
  int          n;
  // Rows: kind (0 mode, 1 control), value written, expected outputs.
  logic [23:0] rows [22] = '{24'h000080, 24'h00d085, 24'h012082,
    24'h01b080, 24'h020080, 24'h028000, 24'h070080, 24'h078080,
    24'h088088, 24'h0a0088, 24'h0b8080, 24'h080000, 24'h0e80f8,
    24'h0c40cc, 24'h1010cf, 24'h1020af, 24'h1030ff, 24'h1c3cf7,
    24'h124202, 24'h110003, 24'h108107, 24'h100007};

  nfom_ctrl nfom_ctrl_inst (.*);
  nfom_host nfom_host_inst (.i_core_clk, .i_pready(o_pready),
    .i_pslverr(o_pslverr), .i_prdata(o_prdata), .o_psel(i_psel),
    .o_penable(i_penable), .o_pwrite(i_pwrite), .o_paddr(i_paddr),
    .o_pwdata(i_pwdata), .o_pstrb(i_pstrb));

  // Clock and a cycle ceiling well above the expected run.
  always #4 i_core_clk = ~i_core_clk;
  always @(posedge i_core_clk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end

  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    compares++;
    if (g !== x) begin
      error_cnt++;
      $display("FAIL %s expected %h seen %h", nm, x, g);
    end
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    nfom_host_inst.xfer(1'b1, a, {24'h0, v}, rd, err);
  endtask
  task automatic rdc(input string nm, input logic [11:0] a,
                     input logic [31:0] x);
    nfom_host_inst.xfer(1'b0, a, 32'h0, rd, err);
    chk(nm, x, rd);
  endtask
  task automatic final_report;
    $display("compares %0d errors %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  // Main sequence: power-up, table, then the awkward cases.
  initial begin
    repeat (20) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    i_por_n <= 1'b1;
    i_xtal_stable <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    rdc("opctl", `NFOM_ADDR_OPCTL, 32'h0);
    rdc("mode", `NFOM_ADDR_MODE, 32'h8);
    $display("test reset done");
    foreach (rows[i]) begin
      d = rows[i][19:12];
      e = rows[i][11:0];
      wr(rows[i][20] ? `NFOM_ADDR_OPCTL : `NFOM_ADDR_MODE, d);
      if (!rows[i][20])
        chk("mode_out", {d[7:3], e[7:0]}, {o_target, o_protocol,
          o_mode_supported, o_brd_mode, o_brd_type_f, o_brd_type_a,
          o_passive_drive, o_modulation_kind, o_auto_resp});
      else
        chk("op_out", e, {o_osc_reg_on, o_rx_enable, o_wakeup_mode_on,
          o_tx_enable, o_fd_on, o_fd_ca_thr, o_fd_peer_thr, o_fd_auto,
          o_low_power_nfc, o_chn_auto, o_am_chn_on, o_pm_chn_on});
    end
    $display("test table done");
    // One channel picked by the path choice; drive setting passed on.
    wr(`NFOM_ADDR_SETUP, 8'ha1);
    wr(`NFOM_ADDR_OPCTL, 8'h20);
    chk("path", 7'h3a, {o_am_chn_on, o_pm_chn_on, o_chn_pick_pm, o_drive_res});
    // A core reset keeps control; only power-up clears it.
    wr(`NFOM_ADDR_OPCTL, 8'h84);
    i_resetn <= 1'b0;
    repeat (3) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    repeat (2) @(posedge i_core_clk);
    rdc("opctl_kept", `NFOM_ADDR_OPCTL, 32'h84);
    rdc("mode_rst", `NFOM_ADDR_MODE, 32'h8);
    i_por_n <= 1'b0;
    repeat (5) @(posedge i_core_clk);
    i_por_n <= 1'b1;
    repeat (4) @(posedge i_core_clk);
    rdc("opctl_por", `NFOM_ADDR_OPCTL, 32'h0);
    $display("test reset kinds done");
    // Field-on sets transmit; end of transfer clears it in active p2p.
    wr(`NFOM_ADDR_MODE, 8'h00);
    wr(`NFOM_ADDR_OPCTL, 8'h80);
    i_field_on_cmd <= 1'b1;
    for (n = 0; n < 10 && o_tx_enable !== 1'b1; n++) @(posedge i_core_clk);
    chk("tx_set", 1, o_tx_enable);
    i_field_on_cmd <= 1'b0;
    i_tx_done <= 1'b1;
    for (n = 0; n < 10 && o_tx_enable !== 1'b0; n++) @(posedge i_core_clk);
    chk("tx_clr", 0, o_tx_enable);
    i_tx_done <= 1'b0;
    // The frame format is only ever set here, outside detection mode.
    wr(`NFOM_ADDR_SETUP, 8'h02);
    chk("frame_fmt", 1, o_frame_fmt);
    $display("test transmit done");
    // Unsupported mode gates both paths but keeps the bits.
    wr(`NFOM_ADDR_MODE, 8'h28);
    wr(`NFOM_ADDR_OPCTL, 8'hc8);
    chk("gated", 0, {o_rx_enable, o_tx_enable});
    rdc("opctl_gate", `NFOM_ADDR_OPCTL, 32'hc8);
    // Mode write without a stable crystal is dropped and flagged.
    i_xtal_stable <= 1'b0;
    repeat (4) @(posedge i_core_clk);
    wr(`NFOM_ADDR_MODE, 8'h00);
    rdc("mode_drop", `NFOM_ADDR_MODE, 32'h28);
    nfom_host_inst.xfer(1'b0, `NFOM_ADDR_STATUS, 32'h0, rd, err);
    chk("drop_flag", 1, rd[0]);
    i_xtal_stable <= 1'b1;
    // An unmapped address answers with an error.
    nfom_host_inst.xfer(1'b0, 12'h040, 32'h0, rd, err);
    chk("slverr", 1, err);
    chk("slverr_data", 0, rd);
    $display("test refusals done");
    final_report();
  end
endmodule

bind nfom_ctrl nfom_ctrl_chk nfom_ctrl_chk_inst (.i_core_clk, .i_resetn,
  .i_psel, .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb,
  .o_pready, .o_osc_reg_on, .o_rx_enable, .o_tx_enable,
  .o_wakeup_mode_on, .o_fd_on, .o_fd_ca_thr, .o_fd_peer_thr, .o_fd_auto,
  .o_low_power_nfc, .o_target, .o_protocol, .o_mode_supported,
  .o_brd_mode, .o_auto_resp);
`default_nettype wire
